// ==== tdmsw_pkg.sv ====
// shared constants of the tdm switch delay and bit error test block
package tdmsw_pkg;
    // connection memory word layout
    localparam int CM_W          = 16;
    localparam int CM_SRC_BIT    = 15;  // high: same port, low: other port
    localparam int CM_MSG_BIT    = 14;  // message mode
    localparam int CM_OE_BIT     = 13;  // per-channel output enable
    localparam int CM_STR_LSB    = 8;   // stream field for 2 to 16 Mbps
    localparam int CM_STR_LSB_32 = 9;   // stream field for 32 Mbps
    localparam int CM_MSG_MSB    = 7;   // message byte occupies bits 7:0
    localparam int CHW_32        = 9;   // channel width of a 32 Mbps stream
    // data memory and throughput latency in frames
    localparam int         BYTE_W         = 8;
    localparam int         BANKS          = 4;
    localparam logic [1:0] LAT_FRAMES_OFF = 2'h2;
    localparam logic [1:0] LAT_FRAMES_ON  = 2'h3;
    localparam logic [7:0] IDLE_BYTE      = 8'hFF;
    localparam int         EXT_BUF_N      = 4;
    // test sequence generator
    localparam int          PRBS_W     = 23;
    localparam int          PRBS_SHORT = 15;
    localparam int          TAP_LONG   = 17;  // x^23 + x^5 + 1
    localparam int          TAP_SHORT  = 13;  // x^15 + x + 1
    localparam logic [22:0] PRBS_SEED  = 23'h7FFFFF;
    localparam logic [22:0] MASK_SHORT = 23'h007FFF;
    localparam logic [22:0] MASK_LONG  = 23'h7FFFFF;
    // error counter
    localparam int          ERR_W   = 16;
    localparam logic [15:0] ERR_MAX = 16'hFFFF;
    // write queue in front of the connection memory
    localparam int FIFO_DEPTH = 16;
endpackage : tdmsw_pkg

// ==== tdmsw_fifo.sv ====
// parameterised flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module tdmsw_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = tdmsw_pkg::FIFO_DEPTH
) (
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    import tdmsw_pkg::*;
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wrPtr;
        logic [PW-1:0]           rdPtr;
        logic [PW:0]             count;
    } tdmsw_fifo_state_t;

    tdmsw_fifo_state_t st_reg;
    tdmsw_fifo_state_t st_next;
    logic              push;
    logic              pop;

    // honest full and empty from the occupancy count
    assign inReady  = (st_reg.count != (PW+1)'(DEPTH));
    assign outValid = (st_reg.count != '0);
    assign outData  = st_reg.mem[st_reg.rdPtr];

    // pointer and storage update
    always_comb
    begin
        st_next = st_reg;
        push    = inValid && inReady;
        pop     = outValid && outReady;
        if (push)
        begin
            st_next.mem[st_reg.wrPtr] = inData;
            st_next.wrPtr             = (st_reg.wrPtr == PW'(DEPTH-1)) ? '0 : st_reg.wrPtr + 1'b1;
        end
        if (pop)
        begin
            st_next.rdPtr = (st_reg.rdPtr == PW'(DEPTH-1)) ? '0 : st_reg.rdPtr + 1'b1;
        end
        st_next.count = st_reg.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
endmodule : tdmsw_fifo

// ==== tdmsw_top.sv ====
// two-port tdm switch core: per-channel drive control, framed delay memory, bit error tester
// Behaviour
// - with idle level select high, per-channel enable bit decides drive or float
// - with select high, enable bit low floats that stream for the whole channel slot
// - with select high, four buffer controls show enable bits of streams 0 to 3 in the current channel
// - input bytes stored at location fixed by stream and channel
// - without input delay, data written in frame N is read in N+2
// - with input delay, data written in frame N is read in N+3
// - only channel offsets change latency, bit alignment never does
// - channel numbers and input delay span the stream's channel count
// - latency without delay is two frames plus n minus m slots
// - latency with delay is three frames minus alpha plus n minus m
// - each port has its own independently enabled test transmitter and receiver
// - transmitter sends 2^15-1 or 2^23-1 sequence on assigned stream and channels
// - allocations are a stream, a start channel and a following-channel count
// - receiver locks on seed, then each mismatched bit bumps 16-bit counter
// - error counter saturates and holds at FFFF
// - separate transmit and receive enables for each port
// - per port, transmit stream plus start channel and transmit length settings
// - per port, receive stream plus start channel and receive length settings
// - on allocated test channels source select and message mode are ignored
// - receiver ignores input delay; software adds delay to start channel
// - during test transmission other channels of that side carry undefined data
// - top connection word bit chooses local or backplane source port
`timescale 1ns/100ps
module tdmsw_top #(
    parameter int NSTR = 32,
    parameter int NCH  = 32
) (
    input  wire logic                                                ref_clk,
    input  wire logic                                                rstn,
    input  wire logic [1:0][NSTR-1:0][tdmsw_pkg::BYTE_W-1:0]         inData,
    output logic [1:0][NSTR-1:0][tdmsw_pkg::BYTE_W-1:0]              outData,
    output logic [1:0][NSTR-1:0]                                     outEn,
    output logic [1:0][tdmsw_pkg::EXT_BUF_N-1:0]                     extBufCtrl,
    output logic                                                     frameSync,
    output logic [$clog2(NCH)-1:0]                                   chanSlot,
    input  wire logic [1:0]                                          idleLevelSelect,
    input  wire logic [1:0]                                          inChanDelayOn,
    input  wire logic [1:0][$clog2(NCH)-1:0]                         inChanDelay,
    input  wire logic                                                cmWrValid,
    output logic                                                     cmWrReady,
    input  wire logic                                                cmWrPort,
    input  wire logic [$clog2(NSTR)-1:0]                             cmWrStream,
    input  wire logic [$clog2(NCH)-1:0]                              cmWrChan,
    input  wire logic [tdmsw_pkg::CM_W-1:0]                          cmWrData,
    input  wire logic [1:0]                                          testTxEn,
    input  wire logic [1:0]                                          testTxLong,
    input  wire logic [1:0][$clog2(NSTR)-1:0]                        testTxStream,
    input  wire logic [1:0][$clog2(NCH)-1:0]                         testTxStart,
    input  wire logic [1:0][$clog2(NCH)-1:0]                         testTxLength,
    input  wire logic [1:0]                                          testRxEn,
    input  wire logic [1:0]                                          testRxLong,
    input  wire logic [1:0][$clog2(NSTR)-1:0]                        testRxStream,
    input  wire logic [1:0][$clog2(NCH)-1:0]                         testRxStart,
    input  wire logic [1:0][$clog2(NCH)-1:0]                         testRxLength,
    output logic [1:0]                                               testRxLocked,
    output logic [1:0][tdmsw_pkg::ERR_W-1:0]                         errorCount
);
    import tdmsw_pkg::*;
    localparam int SW   = $clog2(NSTR);
    // channel range follows the stream rate through NCH
    localparam int CHW  = $clog2(NCH);
    localparam int WQ_W = 1 + SW + CHW + CM_W;

    typedef struct packed {
        logic [1:0][BANKS-1:0][NSTR-1:0][NCH-1:0][BYTE_W-1:0] dm;
        logic [1:0][NSTR-1:0][NCH-1:0][CM_W-1:0]              cm;
        logic [1:0][NSTR-1:0][BYTE_W-1:0]                     outData;
        logic [1:0][NSTR-1:0]                                 outEn;
        logic [1:0][EXT_BUF_N-1:0]                            extBuf;
        logic [CHW-1:0]                                       chan;
        logic [1:0]                                           frame;
        logic                                                 frameSync;
        logic [1:0][PRBS_W-1:0]                               txState;
        logic [1:0][PRBS_W-1:0]                               rxHist;
        logic [1:0]                                           txEnPrev;
        logic [1:0]                                           rxEnPrev;
        logic [1:0]                                           rxLock;
        logic [1:0][ERR_W-1:0]                                errCnt;
    } tdmsw_state_t;

    tdmsw_state_t    st_reg;
    tdmsw_state_t    st_next;
    logic            wqValid;
    logic            wqReady;
    logic [WQ_W-1:0] wqData;

    // feedback bit of the sequence window, oldest bit at the top
    function automatic logic prbsFb(input logic [PRBS_W-1:0] w, input logic isLong);
        if (isLong)
            prbsFb = w[PRBS_W-1] ^ w[TAP_LONG];
        else
            prbsFb = w[PRBS_SHORT-1] ^ w[TAP_SHORT];
    endfunction : prbsFb

    // channel lies within start and start plus following count
    function automatic logic inAlloc(input logic [CHW-1:0] c, input logic [CHW-1:0] s,
                                     input logic [CHW-1:0] len);
        inAlloc = (c >= s) && ({1'b0, c} <= ({1'b0, s} + {1'b0, len}));
    endfunction : inAlloc

    // source stream field of a connection word
    function automatic logic [SW-1:0] cmStream(input logic [CM_W-1:0] w);
        if (CHW >= CHW_32)
            cmStream = SW'(w[CM_OE_BIT-1:CM_STR_LSB_32]);
        else
            cmStream = SW'(w[CM_OE_BIT-1:CM_STR_LSB]);
    endfunction : cmStream

    // connection memory writes are queued and applied between reads
    tdmsw_fifo #(
        .W     (WQ_W),
        .DEPTH (FIFO_DEPTH)
    ) u_cm_queue (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .inValid  (cmWrValid),
        .inReady  (cmWrReady),
        .inData   ({cmWrPort, cmWrStream, cmWrChan, cmWrData}),
        .outValid (wqValid),
        .outReady (wqReady),
        .outData  (wqData)
    );

    // registered outputs
    assign outData      = st_reg.outData;
    assign outEn        = st_reg.outEn;
    assign extBufCtrl   = st_reg.extBuf;
    assign frameSync    = st_reg.frameSync;
    assign chanSlot     = st_reg.chan;
    assign testRxLocked = st_reg.rxLock;
    assign errorCount   = st_reg.errCnt;

    // queue drains unless the entry hits the slot being read this cycle
    assign wqReady = (wqData[CM_W +: CHW] != st_reg.chan);

    // next-state of the whole switch
    always_comb
    begin
        logic             lastChan;
        logic [CHW-1:0]   effDelay;
        logic [CHW-1:0]   logChan;
        logic [1:0]       bank;
        logic [CM_W-1:0]  word;
        logic             src;
        logic [SW-1:0]    sStr;
        logic [CHW-1:0]   sChan;
        logic [7:0]       dByte;
        logic             oe;
        logic [PRBS_W-1:0] txw;
        logic [PRBS_W-1:0] rxw;
        logic [PRBS_W-1:0] mask;
        logic             expBit;
        logic             rxBit;
        lastChan = 1'b0;
        effDelay = '0;
        logChan  = '0;
        bank     = '0;
        word     = '0;
        src      = 1'b0;
        sStr     = '0;
        sChan    = '0;
        dByte    = '0;
        oe       = 1'b0;
        txw      = '0;
        rxw      = '0;
        mask     = '0;
        expBit   = 1'b0;
        rxBit    = 1'b0;
        st_next  = st_reg;

        // slot and frame counters, sync pulses with channel 0
        lastChan          = (st_reg.chan == CHW'(NCH-1));
        st_next.chan      = lastChan ? '0 : st_reg.chan + 1'b1;
        st_next.frame     = lastChan ? st_reg.frame + 2'h1 : st_reg.frame;
        st_next.frameSync = lastChan;

        // apply one queued connection memory write
        if (wqValid && wqReady)
            st_next.cm[wqData[WQ_W-1]][wqData[CM_W+CHW +: SW]][wqData[CM_W +: CHW]] = wqData[CM_W-1:0];

        for (int p = 0; p < 2; p++)
        begin
            // store each input byte at its logical stream and channel
            effDelay = inChanDelayOn[p] ? inChanDelay[p] : '0;
            logChan  = st_reg.chan - effDelay;
            // bytes arriving before the delay wraps belong to the previous frame
            bank     = st_reg.frame - {1'b0, (st_reg.chan < effDelay)};
            for (int s = 0; s < NSTR; s++)
                st_next.dm[p][bank][s][logChan] = inData[p][s];

            // restart the generator from the seed when transmission is enabled
            txw = (testTxEn[p] && !st_reg.txEnPrev[p]) ? PRBS_SEED : st_reg.txState[p];
            st_next.txEnPrev[p] = testTxEn[p];

            for (int s = 0; s < NSTR; s++)
            begin
                word  = st_reg.cm[p][s][st_reg.chan];
                // top bit high keeps the source on this port
                src   = word[CM_SRC_BIT] ? 1'(p) : ~1'(p);
                sStr  = cmStream(word);
                sChan = word[CHW-1:0];
                // read two banks back without delay
                // read three banks back with delay
                // fixed bank distance gives two frames plus n minus m
                // delayed write bank gives three frames minus alpha
                bank  = st_reg.frame - (inChanDelayOn[src] ? LAT_FRAMES_ON : LAT_FRAMES_OFF);
                // slot based addressing, no bit alignment term
                dByte = st_reg.dm[src][bank][sStr][sChan];
                if (word[CM_MSG_BIT])
                    dByte = word[CM_MSG_MSB:0];
                // sequence bytes on the allocated stream and channels
                // stream, start and length choose the transmit slots
                // source and message bits overridden here
                if (testTxEn[p] && (SW'(s) == testTxStream[p])
                    && inAlloc(st_reg.chan, testTxStart[p], testTxLength[p]))
                begin
                    for (int b = BYTE_W-1; b >= 0; b--)
                    begin
                        dByte[b] = testTxLong[p] ? txw[PRBS_W-1] : txw[PRBS_SHORT-1];
                        txw      = {txw[PRBS_W-2:0], prbsFb(txw, testTxLong[p])};
                    end
                end
                // other channels keep switched data, treated as undefined
                // enable bit governs drive while select is high
                // enable low floats the stream for the slot
                oe = word[CM_OE_BIT];
                st_next.outEn[p][s]   = idleLevelSelect[p] ? oe : 1'b1;
                st_next.outData[p][s] = (idleLevelSelect[p] || oe) ? dByte : IDLE_BYTE;
            end
            st_next.txState[p] = txw;

            // buffer controls mirror enable bits of streams 0 to 3 while select is high, else stay high
            for (int k = 0; k < EXT_BUF_N; k++)
                st_next.extBuf[p][k] = idleLevelSelect[p] ? st_reg.cm[p][k][st_reg.chan][CM_OE_BIT] : 1'b1;

            // receiver per port, independent of its transmitter
            // receive enable gates the whole checker
            mask = testRxLong[p] ? MASK_LONG : MASK_SHORT;
            rxw  = st_reg.rxHist[p];
            st_next.rxEnPrev[p] = testRxEn[p];
            // rising receive enable clears count and lock
            if (testRxEn[p] && !st_reg.rxEnPrev[p])
            begin
                st_next.errCnt[p] = '0;
                st_next.rxLock[p] = 1'b0;
                rxw               = '0;
            end
            // physical slot number, input delay not applied
            // stream, start and length choose the compared slots
            // allocation by stream, start and following count
            else if (testRxEn[p] && inAlloc(st_reg.chan, testRxStart[p], testRxLength[p]))
            begin
                for (int b = BYTE_W-1; b >= 0; b--)
                begin
                    rxBit  = inData[p][testRxStream[p]][b];
                    expBit = prbsFb(rxw, testRxLong[p]);
                    if (st_next.rxLock[p])
                    begin
                        // compare bit by bit after lock
                        if ((rxBit != expBit) && (st_next.errCnt[p] != ERR_MAX))
                            st_next.errCnt[p] = st_next.errCnt[p] + 16'h0001;
                        rxw = {rxw[PRBS_W-2:0], expBit};
                    end
                    else
                    begin
                        // lock once the seed has been seen
                        rxw = {rxw[PRBS_W-2:0], rxBit};
                        if ((rxw & mask) == (PRBS_SEED & mask))
                            st_next.rxLock[p] = 1'b1;
                    end
                end
            end
            st_next.rxHist[p] = rxw;
        end
    end

    // state register; outputs show idle high during reset
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            st_reg         <= '0;
            st_reg.outData <= {(2*NSTR){IDLE_BYTE}};
        end
        else
        begin
            st_reg <= st_next;
        end
    end
endmodule : tdmsw_top

// ==== tdmsw_checker.sv ====
// port checker for the tdm switch core
`timescale 1ns/100ps
module tdmsw_checker #(
    parameter int NSTR = 32,
    parameter int NCH  = 32
) (
    input wire logic                                 ref_clk,
    input wire logic                                 rstn,
    input wire logic [1:0][NSTR-1:0]                 outEn,
    input wire logic [1:0][tdmsw_pkg::EXT_BUF_N-1:0] extBufCtrl,
    input wire logic                                 frameSync,
    input wire logic [$clog2(NCH)-1:0]               chanSlot,
    input wire logic [1:0]                           idleLevelSelect,
    input wire logic [1:0]                           testRxEn,
    input wire logic [1:0]                           testRxLocked,
    input wire logic [1:0][tdmsw_pkg::ERR_W-1:0]     errorCount
);
    import tdmsw_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_slot_step: assert property ($past(rstn) |-> chanSlot == $past(chanSlot) + 1'b1)
        else $error("channel slot did not advance by one");
    a_frame_mark: assert property ($past(rstn) |-> frameSync == (chanSlot == 0))
        else $error("frame mark not tied to slot zero");
    a_buf_ctrl_loc: assert property ($past(rstn) && $past(idleLevelSelect[0]) |-> extBufCtrl[0] == outEn[0][3:0])
        else $error("local buffer control differs from enables");
    a_buf_ctrl_bp: assert property ($past(rstn) && $past(idleLevelSelect[1]) |-> extBufCtrl[1] == outEn[1][3:0])
        else $error("backplane buffer control differs from enables");
    a_drive_idle_low: assert property ($past(rstn) && !$past(idleLevelSelect[0]) |-> &outEn[0] && &extBufCtrl[0])
        else $error("streams not all driven with select low");
    a_err_hold_max: assert property (&errorCount[0] && $past(testRxEn[0]) |=> errorCount[0] == ERR_MAX)
        else $error("saturated error count moved");
    a_err_bit_step: assert property (errorCount[0] > $past(errorCount[0]) |-> errorCount[0] - $past(errorCount[0]) <= 16'h0008)
        else $error("error count rose by more than a byte");
    a_err_clear_rise: assert property ($rose(testRxEn[0]) |=> errorCount[0] == 16'h0000 && !testRxLocked[0])
        else $error("receive enable rise did not clear");
    a_err_quiet_unlocked: assert property ($past(rstn) && !$past(testRxLocked[0]) && !testRxLocked[0]
        |-> $stable(errorCount[0]) || errorCount[0] == 16'h0000)
        else $error("errors counted while unlocked");
endmodule : tdmsw_checker

bind tdmsw_top tdmsw_checker #(.NSTR(NSTR), .NCH(NCH)) chk (.ref_clk, .rstn, .outEn, .extBufCtrl, .frameSync,
    .chanSlot, .idleLevelSelect, .testRxEn, .testRxLocked, .errorCount);

// ==== tdmsw_stream_partner.sv ====
// far-side framers: pattern source on every stream, loopback on local stream 3
`timescale 1ns/100ps
module tdmsw_stream_partner #(
    parameter int NSTR = 32,
    parameter int NCH  = 32
) (
    input  wire logic                                        ref_clk,
    input  wire logic [$clog2(NCH)-1:0]                      chanSlot,
    input  wire logic [1:0][NSTR-1:0][tdmsw_pkg::BYTE_W-1:0] outData,
    input  wire logic [1:0][NSTR-1:0]                        outEn,
    input  wire logic                                        loopEn,
    input  wire logic                                        injectErr,
    output logic [1:0][NSTR-1:0][tdmsw_pkg::BYTE_W-1:0]      inData
);
    import tdmsw_pkg::*;
    logic [1:0] frameCnt = 2'h0;
    // frame count lets each byte show which frame it was sent in
    always @(posedge ref_clk)
    begin
        if (chanSlot == NCH - 1) frameCnt <= frameCnt + 2'h1;
    end
    // a floated looped line shows the inverse, never the last driven byte
    always_comb
    begin
        for (int p = 0; p < 2; p++)
            for (int s = 0; s < NSTR; s++)
                inData[p][s] = {frameCnt, p[0], 5'(chanSlot)};
        if (loopEn) inData[0][3] = outEn[0][3] ? outData[0][3] ^ {8{injectErr}} : ~outData[0][3];
    end
endmodule : tdmsw_stream_partner

// ==== tdmsw_top_tb.sv ====
// self-checking bench for the tdm switch core
`timescale 1ns/100ps
module tdmsw_top_tb;
    import tdmsw_pkg::*;
    localparam int NSTR = 4;
    localparam int NCH  = 32;
    typedef struct packed { logic on; logic [4:0] a, m, n; logic same; } tdmsw_lat_t;
    localparam tdmsw_lat_t LAT [4] = '{{1'b0, 5'h00, 5'h00, 5'h0D, 1'b1}, {1'b0, 5'h00, 5'h0D, 5'h00, 1'b0},
                                      {1'b1, 5'h05, 5'h00, 5'h00, 1'b1}, {1'b1, 5'h05, 5'h00, 5'h0D, 1'b0}};
    localparam logic [7:0] SEQ [2][3] = '{'{8'hFF, 8'hFE, 8'h00}, '{8'hFF, 8'hFF, 8'hFE}};
    logic                      ref_clk = 1'b0;
    logic                      rstn = 1'b0;
    logic [1:0][NSTR-1:0][7:0] inData, outData;
    logic [1:0][NSTR-1:0]      outEn;
    logic [1:0][3:0]           extBufCtrl;
    logic [1:0][15:0]          errorCount;
    logic [4:0]                chanSlot, outSlot;
    logic                      frameSync, cmWrReady;
    logic                      cmWrValid = 1'b0, cmWrPort = 1'b0, loopEn = 1'b0, injectErr = 1'b0;
    logic [1:0]                cmWrStream = 2'h0, testRxLocked;
    logic [4:0]                cmWrChan = 5'h00;
    logic [15:0]               cmWrData = 16'h0000;
    logic [1:0]                idleLevelSelect = 2'h3, inChanDelayOn = 2'h0;
    logic [1:0]                testTxEn = 2'h0, testTxLong = 2'h0, testRxEn = 2'h0, testRxLong = 2'h0;
    logic [1:0][4:0]           inChanDelay = 10'h000, testTxStart = 10'h000, testTxLength = 10'h000;
    logic [1:0][4:0]           testRxStart = 10'h000, testRxLength = 10'h000;
    logic [1:0][1:0]           testTxStream = 4'h0, testRxStream = 4'h0;
    logic [7:0]                hist [2][1024];
    logic [9:0]                cyc = 10'h000;
    int                        failures = 0, comparisons = 0;

    tdmsw_top #(.NSTR(NSTR), .NCH(NCH)) uut (.ref_clk, .rstn, .inData, .outData, .outEn, .extBufCtrl, .frameSync,
        .chanSlot, .idleLevelSelect, .inChanDelayOn, .inChanDelay, .cmWrValid, .cmWrReady, .cmWrPort, .cmWrStream,
        .cmWrChan, .cmWrData, .testTxEn, .testTxLong, .testTxStream, .testTxStart, .testTxLength, .testRxEn,
        .testRxLong, .testRxStream, .testRxStart, .testRxLength, .testRxLocked, .errorCount);
    tdmsw_stream_partner #(.NSTR(NSTR), .NCH(NCH)) farEnd (.ref_clk, .chanSlot, .outData, .outEn, .loopEn,
        .injectErr, .inData);

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // input history and the slot whose outputs are now shown
    always @(posedge ref_clk)
    begin
        hist[0][cyc] <= inData[0][1];
        hist[1][cyc] <= inData[1][1];
        outSlot <= chanSlot;
        cyc <= cyc + 10'h001;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wait_slot(input logic [4:0] s);
        for (int k = 0; k < 2 * NCH && outSlot !== s; k++) tick(1);
    endtask : wait_slot

    // request held until ready is seen high at an edge
    task automatic cm_wr(input logic p, input logic [1:0] s, input logic [4:0] c, input logic [15:0] d);
        cmWrValid = 1'b1;
        {cmWrPort, cmWrStream, cmWrChan, cmWrData} = {p, s, c, d};
        do @(posedge ref_clk); while (cmWrReady !== 1'b1);
        #1;
    endtask : cm_wr

    task automatic t_reset;
        cmp(outEn[0], 4'h0);
        cmp(outData[0][0], IDLE_BYTE);
        cmp(errorCount[0], 16'h0000);
        cmp(testRxLocked, 2'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_drive;
        // alternate enables, written back to back
        for (int c = 0; c < NCH; c++)
            cm_wr(1'b0, 2'h2, 5'(c), {2'h2, c[0], 5'h01, 3'h0, 5'(c)});
        cmWrValid = 1'b0;
        tick(2 * NCH);
        for (int i = 0; i < NCH; i++)
        begin
            cmp(outEn[0][2], outSlot[0]);
            cmp(extBufCtrl[0][2], outSlot[0]);
            tick(1);
        end
        idleLevelSelect[0] = 1'b0;
        tick(1);
        wait_slot(5'h04);
        cmp(outEn[0][2], 1'b1);
        cmp(outData[0][2], IDLE_BYTE);
        idleLevelSelect[0] = 1'b1;
        $display("test drive done");
    endtask : t_drive

    task automatic t_delay;
        int l;
        tdmsw_lat_t c;
        for (int i = 0; i < 4; i++)
        begin
            c = LAT[i];
            inChanDelayOn = {2{c.on}};
            inChanDelay = {2{c.a}};
            cm_wr(1'b0, 2'h0, c.n, {c.same, 7'h21, 3'h0, c.m});
            cmWrValid = 1'b0;
            tick(5 * NCH);
            wait_slot(c.n);
            l = c.on ? 3 * NCH - c.a + c.n - c.m : 2 * NCH + c.n - c.m;
            cmp(outData[0][0], hist[c.same ? 0 : 1][cyc - 10'h001 - 10'(l)]);
        end
        $display("test delay done");
    endtask : t_delay

    task automatic t_ber;
        // enabled message words on test slots
        for (int c = 2; c < NCH - 1; c++)
            cm_wr(1'b0, 2'h3, 5'(c), 16'h60AA);
        cmWrValid = 1'b0;
        // receive start counts physical slots, one after the looped transmit
        {testTxStream[0], testTxStart[0], testTxLength[0]} = {2'h3, 5'h02, 5'h1C};
        {testRxStream[0], testRxStart[0], testRxLength[0]} = {2'h3, 5'h03, 5'h1C};
        loopEn = 1'b1;
        for (int md = 0; md < 2; md++)
        begin
            tick(1);
            {testTxEn[0], testRxEn[0]} = 2'h0;
            {testTxLong[0], testRxLong[0]} = {2{md[0]}};
            tick(1);
            wait_slot(5'h1E);
            {testTxEn[0], testRxEn[0]} = 2'h3;
            wait_slot(5'h02);
            for (int b = 0; b < 3; b++)
            begin
                cmp(outData[0][3], SEQ[md][b]);
                tick(1);
            end
            tick(3 * NCH);
            cmp(testRxLocked[0], 1'b1);
            cmp(errorCount[0], 16'h0000);
        end
        // one corrupted byte, then every bit wrong
        wait_slot(5'h0A);
        injectErr = 1'b1;
        tick(1);
        injectErr = 1'b0;
        tick(NCH);
        cmp(errorCount[0], 16'h0008);
        injectErr = 1'b1;
        tick(300 * NCH);
        cmp(errorCount[0], ERR_MAX);
        injectErr = 1'b0;
        testRxEn[0] = 1'b0;
        tick(1);
        testRxEn[0] = 1'b1;
        tick(1);
        cmp(errorCount[0], 16'h0000);
        cmp(testRxLocked[0], 1'b0);
        cmp(errorCount[1] | 16'(testRxLocked[1]), 16'h0000);
        $display("test error tester done");
    endtask : t_ber

    task automatic results;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    // hang guard well beyond the expected run
    initial
    begin
        #(20000 * 10);
        failures++;
        $display("watchdog expired");
        results();
    end

    // reset, then the tests in turn
    initial
    begin
        repeat (12) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        t_reset();
        t_drive();
        t_delay();
        t_ber();
        results();
    end
endmodule : tdmsw_top_tb
